// ### core/tpcg_clock_gen.sv
// Purpose: Divide-by-nine two-phase clock generator and driver
// Assumes: i_sys_clk is the oscillator; sync comes from same-clock logic
// Notes: Phases run regardless of i_rst; only the strobe and re-timed outputs reset
module tpcg_clock_gen (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_power_on_reset_input_n,
  input wire logic i_async_ready_input,
  tpcg_link_if.dev link
);
  import tpcg_pkg::*;

  // Count state; preset so the sequence starts without reset
  logic [CNT_W-1:0] cnt_reg = CNT_FIRST;
  logic [CNT_W-1:0] cnt_next;

  // Phase output flops, preset for the same reason
  logic phi1_reg = 1'b1;
  logic phi1_next;
  logic phi2_reg = 1'b0;
  logic phi2_next;
  logic phi2_ttl_reg = 1'b0;
  logic phi2_ttl_next;

  // Strobe and its early timing slot
  logic phase_one_early_timing;
  logic strobe_n_reg;
  logic strobe_n_next;

  // Re-timed ready and reset
  logic ready_pin_s;
  logic power_on_reset_input_pin_s;
  logic resync_slot;
  logic ready_reg;
  logic ready_next;
  logic reset_reg;
  logic reset_next;

  // Pins pass two flops before any logic looks at them
  tpcg_sync2 #(
    .RESET_VAL(1'b0)
  ) u_ready_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async(i_async_ready_input),
    .o_sync(ready_pin_s)
  );

  // Reset pin sync starts low so the reset output begins asserted
  tpcg_sync2 #(
    .RESET_VAL(1'b0)
  ) u_power_on_reset_input_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async(i_power_on_reset_input_n),
    .o_sync(power_on_reset_input_pin_s)
  );

  // Modulo-nine count; any stray state above the last wraps to zero
  always_comb begin
    if (cnt_reg >= CNT_LAST) begin
      cnt_next = CNT_FIRST;
    end else begin
      cnt_next = cnt_reg + CNT_STEP;
    end
  end

  // Free-running: never held by reset so the phases keep going
  always_ff @(posedge i_sys_clk) begin
    cnt_reg <= cnt_next;
  end

  // Phase decode from the next count keeps outputs aligned to it
  always_comb begin
    phi1_next = tpcg_in_window(cnt_next, PH1_FIRST, PH1_LAST);
    phi2_next = tpcg_in_window(cnt_next, PH2_FIRST, PH2_LAST);
    phi2_ttl_next = phi2_next;
  end

  // Disjoint windows, so the two phases can never overlap
  always_ff @(posedge i_sys_clk) begin
    phi1_reg <= phi1_next;
    phi2_reg <= phi2_next;
    phi2_ttl_reg <= phi2_ttl_next;
  end

  // Early phase one is the last slot before phase one rises
  assign phase_one_early_timing = (cnt_next == EARLY_PH1_STATE);

  // Strobe low one period, only while the processor holds sync
  always_comb begin
    strobe_n_next = !(phase_one_early_timing && link.sync);
  end

  // Strobe idles high through reset
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      strobe_n_reg <= 1'b1;
    end else begin
      strobe_n_reg <= strobe_n_next;
    end
  end

  // One fixed slot per cycle; gives four settled periods
  assign resync_slot = (cnt_next == RESYNC_STATE);

  // Re-timing flops take the synced pins only in their slot
  always_comb begin
    ready_next = ready_reg;
    reset_next = reset_reg;
    if (resync_slot) begin
      ready_next = ready_pin_s;
      // Low from the RC network or the switch both mean reset
      reset_next = !power_on_reset_input_pin_s;
    end
  end

  // Logic reset asserts reset out and drops ready at once
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ready_reg <= 1'b0;
      reset_reg <= 1'b1;
    end else begin
      ready_reg <= ready_next;
      reset_reg <= reset_next;
    end
  end

  // Drive the link; every level comes from a flop but the osc copy
  assign link.phi1 = phi1_reg;
  assign link.phi2 = phi2_reg;
  assign link.phi2_ttl = phi2_ttl_reg;
  assign link.status_strobe_n = strobe_n_reg;
  assign link.ready = ready_reg;
  assign link.reset = reset_reg;
  // A flop would halve the rate, so the clock is passed straight out
  assign link.oscillator_output = i_sys_clk;
endmodule : tpcg_clock_gen

// ### core/tpcg_cpu_end.sv
// Purpose: Processor and status latch that sit across the link
// Assumes: Same system clock as the generator; link levels are local
// Notes: Machine cycle is T1, T2, optional waits, T3
module tpcg_cpu_end #(
  parameter logic [7:0] STATUS_WORD = 8'h01
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  tpcg_link_if.cpu link,
  output logic [tpcg_pkg::ADDR_W-1:0] o_address,
  output logic [tpcg_pkg::DATA_W-1:0] o_status_latch,
  output logic o_waiting
);
  import tpcg_pkg::*;

  tpcg_tstate_t state_reg;
  tpcg_tstate_t state_next;
  logic [ADDR_W-1:0] pc_reg;
  logic [ADDR_W-1:0] pc_next;
  logic phi1_q_reg;
  logic strobe_q_reg;
  logic sync_reg;
  logic sync_next;
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] data_next;
  logic [DATA_W-1:0] latch_reg;
  logic [DATA_W-1:0] latch_next;
  logic t_start;
  logic strobe_rise;
  logic waiting_reg;
  logic waiting_next;

  // Each processor state opens on a phase one rise
  assign t_start = link.phi1 && !phi1_q_reg;
  assign strobe_rise = link.status_strobe_n && !strobe_q_reg;

  // Sequence the machine cycle
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    if (link.reset) begin
      state_next = TPCG_IDLE;
      pc_next = PC_RESET;
    end else if (t_start) begin
      case (state_reg)
        TPCG_IDLE: state_next = TPCG_T1;
        TPCG_T1: state_next = TPCG_T2;
        TPCG_T2,
        TPCG_TW: state_next = link.ready ? TPCG_T3 : TPCG_TW;
        TPCG_T3: begin
          state_next = TPCG_T1;
          pc_next = pc_reg + PC_STEP;
        end
        default: state_next = TPCG_IDLE;
      endcase
    end
  end

  // Sync and status word for the whole first state
  always_comb begin
    sync_next = (state_next == TPCG_T1);
    data_next = sync_next ? STATUS_WORD : DATA_IDLE;
    latch_next = strobe_rise ? data_reg : latch_reg;
    // Registered so the wait flag comes straight from a flop
    waiting_next = (state_next == TPCG_TW);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg <= TPCG_IDLE;
      pc_reg <= PC_RESET;
      phi1_q_reg <= 1'b0;
      strobe_q_reg <= 1'b1;
      sync_reg <= 1'b0;
      data_reg <= DATA_IDLE;
      latch_reg <= DATA_IDLE;
      waiting_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      phi1_q_reg <= link.phi1;
      strobe_q_reg <= link.status_strobe_n;
      sync_reg <= sync_next;
      data_reg <= data_next;
      latch_reg <= latch_next;
      waiting_reg <= waiting_next;
    end
  end

  assign link.sync = sync_reg;
  assign link.data = data_reg;
  assign o_address = pc_reg;
  assign o_status_latch = latch_reg;
  assign o_waiting = waiting_reg;
endmodule : tpcg_cpu_end

// ### core/tpcg_link_if.sv
// Purpose: Wires between the clock generator and the processor side
// Assumes: Both ends run on the same system clock
// Notes: No clocking block; the bench joins the two ends here
interface tpcg_link_if;
  import tpcg_pkg::*;

  logic phi1;
  logic phi2;
  logic phi2_ttl;
  logic oscillator_output;
  logic status_strobe_n;
  logic ready;
  logic reset;
  logic sync;
  logic [DATA_W-1:0] data;

  // Clock generator end
  modport dev (
    output phi1,
    output phi2,
    output phi2_ttl,
    output oscillator_output,
    output status_strobe_n,
    output ready,
    output reset,
    input sync
  );

  // Processor and status-latching controller end
  modport cpu (
    input phi1,
    input phi2,
    input phi2_ttl,
    input oscillator_output,
    input status_strobe_n,
    input ready,
    input reset,
    output sync,
    output data
  );
endinterface : tpcg_link_if

// ### core/tpcg_pkg.sv
// Purpose: Shared constants and types for the two-phase clock generator
// Assumes: One system clock that stands for the crystal oscillator
// Notes: Count states run 0 to 8, one per oscillator period
package tpcg_pkg;

  // Oscillator periods per processor clock period
  localparam int unsigned DIV_RATIO = 9;
  localparam int unsigned CNT_W = 4;

  // Count states for each phase window
  localparam logic [3:0] CNT_FIRST = 4'h0;
  localparam logic [3:0] CNT_LAST = 4'h8;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam logic [3:0] PH1_FIRST = 4'h0;
  localparam logic [3:0] PH1_LAST = 4'h1;
  localparam logic [3:0] PH2_FIRST = 4'h2;
  localparam logic [3:0] PH2_LAST = 4'h6;

  // Early phase one slot: six periods after phase two rises
  localparam logic [3:0] EARLY_PH1_STATE = 4'h8;

  // Ready and reset update here, four periods before phase two
  localparam logic [3:0] RESYNC_STATE = 4'h7;

  // Processor side widths and reset values
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [7:0] DATA_IDLE = 8'h00;

  // Processor machine cycle states
  typedef enum logic [2:0] {
    TPCG_IDLE,
    TPCG_T1,
    TPCG_T2,
    TPCG_TW,
    TPCG_T3
  } tpcg_tstate_t;

  // True when a count lies inside an inclusive window
  function automatic logic tpcg_in_window(
    input logic [3:0] cnt,
    input logic [3:0] first,
    input logic [3:0] last
  );
    tpcg_in_window = (cnt >= first) && (cnt <= last);
  endfunction : tpcg_in_window

endpackage : tpcg_pkg

// ### core/tpcg_sync2.sv
// Purpose: Two-flop synchroniser for one pin level
// Assumes: Input is asynchronous to i_sys_clk
// Notes: First stage feeds only the second stage
module tpcg_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);
  import tpcg_pkg::*;

  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  // Next values of the two stages
  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
  end

  // Register stages; reset loads a constant only
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;
endmodule : tpcg_sync2

// ### testbench/tpcg_link_sva.sv
// Purpose: Timing checks on the generator to processor link
// Assumes: One clock; i_rst synchronous, active high
// Notes: Needs no counter; phases give the slot
module tpcg_link_sva (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic phi1,
  input wire logic phi2,
  input wire logic phi2_ttl,
  input wire logic oscillator_output,
  input wire logic status_strobe_n,
  input wire logic ready,
  input wire logic reset,
  input wire logic sync
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // Phase two start, then sync seen in the late slot
  sequence s_ph2_start;
    $rose(phi2);
  endsequence
  sequence s_late_sync;
    s_ph2_start ##5 sync;
  endsequence
  property p_ph1_len;
    $rose(phi1) |=> phi1 ##1 (!phi1 && phi2);
  endproperty
  a_ph1_len: assert property (p_ph1_len)
    else $error("phase one width wrong");
  property p_ph2_len;
    s_ph2_start |-> phi2[*5] ##1 (!phi2 && !phi1)[*2] ##1 phi1;
  endproperty
  a_ph2_len: assert property (p_ph2_len)
    else $error("phase two width or gap wrong");
  property p_apart;
    !(phi1 && phi2);
  endproperty
  a_apart: assert property (p_apart)
    else $error("phases overlap");
  property p_period;
    $rose(phi1) |=> (!$rose(phi1))[*8] ##1 $rose(phi1);
  endproperty
  a_period: assert property (p_period)
    else $error("phase period not nine");
  property p_ttl;
    phi2_ttl == phi2;
  endproperty
  a_ttl: assert property (p_ttl)
    else $error("ttl copy differs");
  // Both halves checked; a stuck copy fails one of them
  property p_osc;
    @(negedge i_sys_clk) oscillator_output;
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator copy differs");
  property p_osc_low;
    !oscillator_output;
  endproperty
  a_osc_low: assert property (p_osc_low)
    else $error("oscillator copy not low");
  property p_stb_gate;
    !status_strobe_n |-> $past(sync) && $past(phi2, 2) && !$past(phi2);
  endproperty
  a_stb_gate: assert property (p_stb_gate)
    else $error("strobe without sync or off slot");
  property p_stb_due;
    s_late_sync |=> !status_strobe_n ##1 status_strobe_n;
  endproperty
  a_stb_due: assert property (p_stb_due)
    else $error("strobe missing or too long");
  property p_resync;
    ($changed(ready) || $changed(reset)) |-> $past(phi2) && !phi2;
  endproperty
  a_resync: assert property (p_resync)
    else $error("ready or reset moved off slot");
endmodule : tpcg_link_sva

// ### testbench/tpcg_tb.sv
// Purpose: Self-checking bench for generator and processor end
// Assumes: 20 MHz clock; pins change once per processor cycle
// Notes: Model count locks on the first phase one rise
module tpcg_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tpcg_pkg::*;
  localparam logic [7:0] WORD = 8'ha5;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic por_n = 1'b1;
  logic rdy_in = 1'b1;
  logic [31:0] rnd = 32'hbbf32152;
  logic [15:0] address;
  logic [7:0] latch;
  logic waiting;
  logic r, s, pr, pp, rr, rd, m_rdy, m_rst;
  bit locked, armed, fresh;
  int m_st = 0;
  logic [15:0] m_pc = 16'h0000;
  logic [7:0] lat_q[$];
  logic p1_prev = 1'b1;
  int n_errors = 0;
  int total_checks = 0;
  int cnt = 0;
  int since = 0;
  tpcg_link_if link ();
  tpcg_clock_gen i_tpcg_clock_gen (.i_sys_clk(sys_clk), .i_rst(rst),
    .i_power_on_reset_input_n(por_n), .i_async_ready_input(rdy_in),
    .link(link.dev));
  tpcg_cpu_end #(.STATUS_WORD(WORD)) i_tpcg_cpu_end (.i_sys_clk(sys_clk),
    .i_rst(rst), .link(link.cpu), .o_address(address),
    .o_status_latch(latch), .o_waiting(waiting));
  tpcg_link_sva i_tpcg_link_sva (.i_sys_clk(sys_clk), .i_rst(rst),
    .phi1(link.phi1), .phi2(link.phi2), .phi2_ttl(link.phi2_ttl),
    .oscillator_output(link.oscillator_output),
    .status_strobe_n(link.status_strobe_n), .ready(link.ready),
    .reset(link.reset), .sync(link.sync));
  // Free-running oscillator
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  // Hang guard, a little past the planned run
  initial begin
    repeat (4000) @(posedge sys_clk);
    n_errors++;
    conclude();
  end
  // Per-edge model; pins move only in count 1, far from the slot
  initial begin
    for (int i = 0; i < 3720; i++) begin
      @(posedge sys_clk);
      r = rst;
      s = link.sync;
      rr = link.reset;
      rd = link.ready;
      pr = rdy_in;
      pp = por_n;
      // Second, short reset mid-run, launched in count 1
      if (i == 1800) rst <= 1'b1;
      if (i == 19 || i == 1803) rst <= 1'b0;
      since = r ? 0 : since + 1;
      cnt = (cnt + 1) % 9;
      if (locked && cnt == 1) begin
        rnd = xs(rnd);
        rdy_in <= rnd[0] | rnd[1];
        por_n <= rnd[7:3] != 5'h00;
      end
      if (r) begin
        m_rdy = 1'b0;
        m_rst = 1'b1;
      end else if (cnt == 7) begin
        m_rdy = pr;
        m_rst = !pp;
      end
      // Processor cycle model: 0 idle, 1 T1, 2 T2, 3 wait, 4 T3
      if (r || rr) begin
        m_st = 0;
        m_pc = 16'h0000;
      end else if (cnt == 1) begin
        case (m_st)
          0: m_st = 1;
          1: m_st = 2;
          2, 3: m_st = rd ? 4 : 3;
          4: begin
            m_st = 1;
            m_pc = m_pc + 16'h0001;
          end
          default: m_st = 0;
        endcase
      end
      if (cnt == 1 && since >= 12) armed = 1;
      #1;
      if (!locked && link.phi1 === 1'b1 && p1_prev === 1'b0) begin
        locked = 1;
        cnt = 0;
      end
      p1_prev = link.phi1;
      if (locked) begin
        chk("phi1", link.phi1, cnt < 2);
        chk("phi2", link.phi2, cnt >= 2 && cnt <= 6);
        chk("phi2_ttl", link.phi2_ttl, cnt >= 2 && cnt <= 6);
        chk("osc", link.oscillator_output, 1'b1);
        chk("strobe_n", link.status_strobe_n, !(cnt == 8 && s && !r));
        chk("sync", link.sync, m_st == 1);
        chk("waiting", waiting, m_st == 3);
        chk("pc", address, m_pc);
      end
      if (armed) begin
        chk("ready", link.ready, m_rdy);
        chk("reset", link.reset, m_rst);
      end
      if (armed && link.sync === 1'b1) chk("data", link.data, WORD);
      // Look before arming: a reset rising inside T1 still shows sync
      if (fresh && link.sync === 1'b1) begin
        chk("address", address, 16'h0000);
        fresh = 0;
      end
      if (link.reset === 1'b1) fresh = 1;
      // A first state cut short by reset leaves the bus idle
      if (link.status_strobe_n === 1'b0) begin
        lat_q.push_back((m_st == 1) ? WORD : DATA_IDLE);
      end
      if (cnt == 1 && lat_q.size() > 0) begin
        chk("latch", latch, lat_q.pop_front());
      end
    end
    conclude();
  end
endmodule : tpcg_tb
